// [verilog/dpsl_consts.svh]
`ifndef DPSL_CONSTS_SVH
`define DPSL_CONSTS_SVH

// Clock rate and park time limits.
`define DPSL_CLK_MHZ 100
`define DPSL_NORM_PARK_MS 20
`define DPSL_FAST_PARK_US 32
`define DPSL_NORM_PARK_CYC (`DPSL_NORM_PARK_MS * 1000 * `DPSL_CLK_MHZ)
`define DPSL_FAST_PARK_CYC (`DPSL_FAST_PARK_US * `DPSL_CLK_MHZ)
`define DPSL_PARK_CNT_W 22

// Source envelope, landscape orientation.
`define DPSL_LAND_H_MIN 12'h140
`define DPSL_LAND_H_MAX 12'h500
`define DPSL_LAND_V_MIN 12'h0C8
`define DPSL_LAND_V_MAX 12'h320
`define DPSL_3D_V_MAX 12'h2D0
`define DPSL_RATE_MIN 12'h00A
`define DPSL_PAR_RATE_MAX 12'h0F2
`define DPSL_DSI_RATE_MAX 12'h07A
`define DPSL_3D_RATE_A 12'h064
`define DPSL_3D_RATE_B 12'h078
`define DPSL_RATE_TOL 12'h002
`define DPSL_BT_H 12'h2D0
`define DPSL_NTSC_V 12'h0F0
`define DPSL_NTSC_RATE 12'h03C
`define DPSL_PAL_V 12'h120
`define DPSL_PAL_RATE 12'h032

// Largest image the mirror array shows.
`define DPSL_DMD_H_MAX 12'h356
`define DPSL_DMD_V_MAX 12'h1E0

`endif

// [verilog/dpsl_pkg.sv]
package dpsl_pkg;
    typedef enum logic [1:0] {
        DPSL_IF_PARALLEL,
        DPSL_IF_DSI,
        DPSL_IF_BT_NTSC,
        DPSL_IF_BT_PAL
    } dpsl_iface_t;

    typedef enum logic [1:0] {
        DPSL_ST_RUN,
        DPSL_ST_PARKING,
        DPSL_ST_PARKED
    } dpsl_park_state_t;
endpackage : dpsl_pkg

// [verilog/dpsl_src_check.sv]
`include "dpsl_consts.svh"

module dpsl_src_check
    import dpsl_pkg::*;
(
    input wire logic core_clk, // System clock.
    input wire logic sys_rst, // Synchronous reset, active high.
    input wire dpsl_iface_t src_iface, // Active input interface.
    input wire logic src_is_3d, // Source is frame sequential 3D.
    input wire logic src_portrait, // Source is portrait.
    input wire logic [11:0] src_hsize, // Measured source width.
    input wire logic [11:0] src_vsize, // Measured source height.
    input wire logic [11:0] src_rate_hz, // Measured frame rate in Hz.
    output logic src_fault // Source outside the accepted envelope.
);
    logic fault_r;
    logic fault_nxt;
    logic [11:0] land_h;
    logic [11:0] land_v;

    function automatic logic in_rng(input logic [11:0] v, input logic [11:0] lo, input logic [11:0] hi);
        in_rng = (v >= lo) && (v <= hi);
    endfunction : in_rng

    function automatic logic near(input logic [11:0] v, input logic [11:0] c);
        near = in_rng(v, c - `DPSL_RATE_TOL, c + `DPSL_RATE_TOL);
    endfunction : near

    always_comb begin
        // On the parallel and DSI paths, portrait limits are the landscape ones with the axes exchanged.
        land_h = src_portrait ? src_vsize : src_hsize;
        land_v = src_portrait ? src_hsize : src_vsize;
        fault_nxt = 1'b1;
        case (src_iface)
            DPSL_IF_PARALLEL: begin
                if (src_is_3d) begin
                    fault_nxt = !(in_rng(land_h, `DPSL_LAND_H_MIN, `DPSL_LAND_H_MAX)
                        && in_rng(land_v, `DPSL_LAND_V_MIN, `DPSL_3D_V_MAX)
                        && (near(src_rate_hz, `DPSL_3D_RATE_A) || near(src_rate_hz, `DPSL_3D_RATE_B)));
                end else begin
                    fault_nxt = !(in_rng(land_h, `DPSL_LAND_H_MIN, `DPSL_LAND_H_MAX)
                        && in_rng(land_v, `DPSL_LAND_V_MIN, `DPSL_LAND_V_MAX)
                        && in_rng(src_rate_hz, `DPSL_RATE_MIN, `DPSL_PAR_RATE_MAX));
                end
            end
            DPSL_IF_DSI: begin
                // 3D is not offered on this path, so it is a fault.
                fault_nxt = src_is_3d || !(in_rng(land_h, `DPSL_LAND_H_MIN, `DPSL_LAND_H_MAX)
                    && in_rng(land_v, `DPSL_LAND_V_MIN, `DPSL_LAND_V_MAX)
                    && in_rng(src_rate_hz, `DPSL_RATE_MIN, `DPSL_DSI_RATE_MAX));
            end
            DPSL_IF_BT_NTSC: begin
                fault_nxt = src_is_3d || src_portrait || src_hsize != `DPSL_BT_H
                    || src_vsize != `DPSL_NTSC_V || !near(src_rate_hz, `DPSL_NTSC_RATE);
            end
            DPSL_IF_BT_PAL: begin
                fault_nxt = src_is_3d || src_portrait || src_hsize != `DPSL_BT_H
                    || src_vsize != `DPSL_PAL_V || !near(src_rate_hz, `DPSL_PAL_RATE);
            end
            default: begin
                fault_nxt = 1'b1;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            fault_r <= 1'b0;
        end else begin
            fault_r <= fault_nxt;
        end
    end

    assign src_fault = fault_r;

    par_rate_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (src_iface == DPSL_IF_PARALLEL && !src_is_3d && !src_portrait && src_hsize == 12'h500
         && src_vsize == 12'h320 && src_rate_hz == 12'h0F2) |=> !src_fault)
        else $error("parallel 2D envelope corner refused");
    par_3d_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (src_iface == DPSL_IF_PARALLEL && src_is_3d && src_hsize == 12'h500 && src_vsize == 12'h2D0
         && !src_portrait && (src_rate_hz == 12'h06E || src_rate_hz == 12'h061)) |=> src_fault)
        else $error("3D rate outside tolerance accepted");
    dsi_rate_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (src_iface == DPSL_IF_DSI && src_rate_hz > 12'h07A) |=> src_fault)
        else $error("DSI rate above limit accepted");
    fault_flag_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (src_hsize > 12'h500 && !src_portrait) |=> src_fault)
        else $error("oversize source not flagged");
endmodule : dpsl_src_check

// [verilog/dpsl_park_ctrl.sv]
`include "dpsl_consts.svh"

module dpsl_park_ctrl
    import dpsl_pkg::*;
#(
    parameter int unsigned NORM_PARK_CYC = `DPSL_NORM_PARK_CYC
) (
    input wire logic core_clk, // System clock, 100 MHz.
    input wire logic sys_rst, // Synchronous reset, active high.
    input wire logic normal_park_request_n, // Normal park request, active low.
    input wire logic fast_park_request_n, // Fast park request, active low.
    input wire logic rotate_portrait, // Control port: rotate portrait input.
    input wire dpsl_iface_t src_iface, // Active input interface.
    input wire logic src_is_3d, // Source is frame sequential 3D.
    input wire logic src_portrait, // Source is portrait.
    input wire logic [11:0] src_hsize, // Measured source width.
    input wire logic [11:0] src_vsize, // Measured source height.
    input wire logic [11:0] src_rate_hz, // Measured frame rate in Hz.
    output logic mirror_park_active, // Park sequence in progress.
    output logic mirror_parked, // Mirror array parked.
    output logic [11:0] disp_hsize, // Displayed width.
    output logic [11:0] disp_vsize, // Displayed height.
    output logic disp_rotated, // Image rotated minus 90 degrees.
    output logic src_fault // Source outside the accepted envelope.
);
    localparam logic [`DPSL_PARK_CNT_W-1:0] FAST_CYC = `DPSL_PARK_CNT_W'(`DPSL_FAST_PARK_CYC);
    localparam logic [`DPSL_PARK_CNT_W-1:0] NORM_CYC = `DPSL_PARK_CNT_W'(NORM_PARK_CYC);

    dpsl_park_state_t state_r;
    dpsl_park_state_t state_nxt;
    logic [`DPSL_PARK_CNT_W-1:0] cnt_r;
    logic [`DPSL_PARK_CNT_W-1:0] cnt_nxt;
    logic norm_q_r;
    logic fast_q_r;
    logic norm_fell;
    logic fast_fell;
    logic [11:0] hsize_r;
    logic [11:0] hsize_nxt;
    logic [11:0] vsize_r;
    logic [11:0] vsize_nxt;
    logic rot_r;
    logic rot_nxt;

    function automatic logic [11:0] clamp(input logic [11:0] v, input logic [11:0] lim);
        clamp = (v > lim) ? lim : v;
    endfunction : clamp

    assign norm_fell = norm_q_r && !normal_park_request_n;
    assign fast_fell = fast_q_r && !fast_park_request_n;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            DPSL_ST_RUN: begin
                if (fast_fell) begin
                    state_nxt = DPSL_ST_PARKING;
                    cnt_nxt = FAST_CYC - 1'b1;
                end else if (norm_fell) begin
                    state_nxt = DPSL_ST_PARKING;
                    cnt_nxt = NORM_CYC - 1'b1;
                end
            end
            DPSL_ST_PARKING: begin
                // A fast request during a normal park shortens the remaining time.
                if (fast_fell && cnt_r > FAST_CYC - 1'b1) begin
                    cnt_nxt = FAST_CYC - 1'b1;
                end else if (cnt_r == '0) begin
                    state_nxt = DPSL_ST_PARKED;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            DPSL_ST_PARKED: begin
                // Resume only once both requests are released; the host's long pulse keeps this clean.
                if (normal_park_request_n && fast_park_request_n) begin
                    state_nxt = DPSL_ST_RUN;
                end
            end
            default: begin
                state_nxt = DPSL_ST_RUN;
                cnt_nxt = '0;
            end
        endcase
    end

    always_comb begin
        rot_nxt = rotate_portrait && src_portrait;
        hsize_nxt = clamp(rot_nxt ? src_vsize : src_hsize, `DPSL_DMD_H_MAX);
        vsize_nxt = clamp(rot_nxt ? src_hsize : src_vsize, `DPSL_DMD_V_MAX);
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_r <= DPSL_ST_RUN;
            cnt_r <= '0;
            // History follows the pins during reset, so a request held low across reset is not a fall.
            norm_q_r <= normal_park_request_n;
            fast_q_r <= fast_park_request_n;
            hsize_r <= '0;
            vsize_r <= '0;
            rot_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            norm_q_r <= normal_park_request_n;
            fast_q_r <= fast_park_request_n;
            hsize_r <= hsize_nxt;
            vsize_r <= vsize_nxt;
            rot_r <= rot_nxt;
        end
    end

    assign mirror_park_active = (state_r == DPSL_ST_PARKING);
    assign mirror_parked = (state_r == DPSL_ST_PARKED);
    assign disp_hsize = hsize_r;
    assign disp_vsize = vsize_r;
    assign disp_rotated = rot_r;

    dpsl_src_check u_src_check (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .src_iface(src_iface),
        .src_is_3d(src_is_3d),
        .src_portrait(src_portrait),
        .src_hsize(src_hsize),
        .src_vsize(src_vsize),
        .src_rate_hz(src_rate_hz),
        .src_fault(src_fault)
    );

    // Cycles spent parking, read only by the checks below.
    logic [`DPSL_PARK_CNT_W-1:0] park_age_r;
    logic fast_pend_r;
    logic [12:0] fast_age_r;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            park_age_r <= '0;
            fast_pend_r <= 1'b0;
            fast_age_r <= '0;
        end else begin
            park_age_r <= (state_r == DPSL_ST_PARKING) ? park_age_r + 1'b1 : '0;
            fast_pend_r <= (fast_fell && state_r != DPSL_ST_PARKED) || (fast_pend_r && state_r != DPSL_ST_PARKED);
            fast_age_r <= (fast_pend_r && state_r != DPSL_ST_PARKED) ? fast_age_r + 1'b1 : '0;
        end
    end

    norm_limit_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        park_age_r <= NORM_CYC)
        else $error("normal park took too long");
    fast_limit_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        fast_age_r <= 13'(`DPSL_FAST_PARK_CYC))
        else $error("fast park took too long");
    park_start_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state_r == DPSL_ST_RUN && norm_fell) |=> mirror_park_active && !mirror_parked)
        else $error("normal park request not started");
    rot_swap_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (rotate_portrait && src_portrait && src_hsize == 12'h1E0 && src_vsize == 12'h356)
        |=> disp_rotated && disp_hsize == 12'h356 && disp_vsize == 12'h1E0)
        else $error("portrait rotation wrong");
    dmd_size_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        disp_hsize <= 12'h356 && disp_vsize <= 12'h1E0 && ($past(src_hsize) < 12'h100 && !$past(rot_nxt)
        -> disp_hsize == $past(src_hsize)))
        else $error("displayed image size wrong");
endmodule : dpsl_park_ctrl

// [sim/dpsl_host_model.sv]
module dpsl_host_model #(
    parameter int HOLD_CYC = 20
) (
    input wire logic core_clk, // System clock.
    output logic normal_park_request_n, // Normal park request, active low.
    output logic fast_park_request_n // Fast park request, active low.
);
    timeunit 1ns;
    timeprecision 1ps;
    int cyc = 0;
    int last_chg = 0;
    initial begin
        normal_park_request_n = 1'b1;
        fast_park_request_n = 1'b1;
    end
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
    end
    // The hold is scaled down from the real minimum so that a run stays short.
    task automatic set_normal(input logic v);
        @(negedge core_clk);
        while (cyc - last_chg < HOLD_CYC) @(negedge core_clk);
        normal_park_request_n = v;
        last_chg = cyc;
    endtask : set_normal
    task automatic set_fast(input logic v);
        @(negedge core_clk);
        fast_park_request_n = v;
    endtask : set_fast
endmodule : dpsl_host_model

// [sim/tb_top.sv]
module tb_top;
    import dpsl_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int N = 5000;
    localparam int F = 3200;
    logic core_clk, sys_rst, rotate_portrait, src_is_3d, src_portrait;
    dpsl_iface_t src_iface;
    logic [11:0] src_hsize, src_vsize, src_rate_hz, disp_hsize, disp_vsize;
    logic normal_park_request_n, fast_park_request_n;
    logic mirror_park_active, mirror_parked, disp_rotated, src_fault;
    int bad_count = 0;
    int samples_checked = 0;
    int k;
    dpsl_host_model #(.HOLD_CYC(20)) u_dpsl_host_model (.core_clk(core_clk),
        .normal_park_request_n(normal_park_request_n), .fast_park_request_n(fast_park_request_n));
    dpsl_park_ctrl #(.NORM_PARK_CYC(N)) u_dpsl_park_ctrl (.core_clk(core_clk), .sys_rst(sys_rst),
        .normal_park_request_n(normal_park_request_n), .fast_park_request_n(fast_park_request_n),
        .rotate_portrait(rotate_portrait), .src_iface(src_iface), .src_is_3d(src_is_3d),
        .src_portrait(src_portrait), .src_hsize(src_hsize), .src_vsize(src_vsize),
        .src_rate_hz(src_rate_hz), .mirror_park_active(mirror_park_active),
        .mirror_parked(mirror_parked), .disp_hsize(disp_hsize), .disp_vsize(disp_vsize),
        .disp_rotated(disp_rotated), .src_fault(src_fault));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic conclude();
        $display("bad_count=%0d samples_checked=%0d", bad_count, samples_checked);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude
    task automatic chk1(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t: flag got %b expected %b", $time, got, exp);
        end
    endtask : chk1
    task automatic chk12(input logic [11:0] got, input logic [11:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t: size got %h expected %h", $time, got, exp);
        end
    endtask : chk12
    task automatic chk_cnt(input int got, input int exp);
        samples_checked++;
        if (got != exp) begin
            bad_count++;
            $display("ERROR %0t: park took %0d edges, expected %0d", $time, got, exp);
        end
    endtask : chk_cnt
    // Counts edges from the one that takes the fall until parked shows.
    task automatic wait_parked(output int n);
        n = 0;
        do begin
            @(posedge core_clk);
            #1;
            n++;
            if (n == 2) chk1(mirror_park_active, 1'b1);
        end while (mirror_parked !== 1'b1 && n < N + 10);
        if (mirror_parked !== 1'b1) begin
            bad_count++;
            $display("ERROR %0t: park never completed", $time);
            conclude();
        end
        chk1(mirror_park_active, 1'b0);
    endtask : wait_parked
    task automatic release_both();
        u_dpsl_host_model.set_fast(1'b1);
        u_dpsl_host_model.set_normal(1'b1);
        repeat (2) @(posedge core_clk);
        #1;
        chk1(mirror_parked, 1'b0);
    endtask : release_both
    task automatic sc_normal_park();
        u_dpsl_host_model.set_normal(1'b0);
        wait_parked(k);
        chk_cnt(k, N + 1);
        u_dpsl_host_model.set_fast(1'b0);
        repeat (5) @(posedge core_clk);
        #1;
        chk1(mirror_parked, 1'b1);
        chk1(mirror_park_active, 1'b0);
        release_both();
    endtask : sc_normal_park
    task automatic sc_fast_park();
        u_dpsl_host_model.set_fast(1'b0);
        wait_parked(k);
        chk_cnt(k, F + 1);
        release_both();
    endtask : sc_fast_park
    // A fast request while a normal park runs must still meet the fast limit.
    task automatic sc_fast_cut();
        u_dpsl_host_model.set_normal(1'b0);
        repeat (100) @(posedge core_clk);
        u_dpsl_host_model.set_fast(1'b0);
        wait_parked(k);
        chk_cnt(k, F + 1);
    endtask : sc_fast_cut
    // A request already low when reset ends must not start a park.
    task automatic sc_mid_reset();
        u_dpsl_host_model.set_fast(1'b1);
        @(negedge core_clk);
        sys_rst = 1'b1;
        repeat (2) @(negedge core_clk);
        chk1(mirror_parked, 1'b0);
        sys_rst = 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
        chk1(mirror_park_active, 1'b0);
        chk1(mirror_parked, 1'b0);
        u_dpsl_host_model.set_normal(1'b1);
    endtask : sc_mid_reset
    task automatic put_src(input dpsl_iface_t i, input logic d3, pt, rot, input logic [11:0] h, v, r);
        src_iface = i;
        src_is_3d = d3;
        src_portrait = pt;
        // The control setting is a level here; the serial port's rate limit lies with the host.
        rotate_portrait = rot;
        src_hsize = h;
        src_vsize = v;
        src_rate_hz = r;
    endtask : put_src
    task automatic src(input dpsl_iface_t i, input logic d3, pt, rot, input logic [11:0] h, v, r,
        input logic f, input logic [11:0] eh, ev);
        @(negedge core_clk);
        put_src(i, d3, pt, rot, h, v, r);
        @(posedge core_clk);
        #1;
        chk1(src_fault, f);
        chk12(disp_hsize, eh);
        chk12(disp_vsize, ev);
        chk1(disp_rotated, rot & pt);
    endtask : src
    task automatic sc_envelope();
        src(DPSL_IF_PARALLEL, 0, 0, 0, 12'h500, 12'h320, 12'h0F2, 0, 12'h356, 12'h1E0);
        src(DPSL_IF_PARALLEL, 0, 0, 0, 12'h501, 12'h320, 12'h0F2, 1, 12'h356, 12'h1E0);
        src(DPSL_IF_PARALLEL, 0, 0, 0, 12'h140, 12'h0C8, 12'h00A, 0, 12'h140, 12'h0C8);
        src(DPSL_IF_PARALLEL, 0, 0, 0, 12'h13F, 12'h0C8, 12'h00A, 1, 12'h13F, 12'h0C8);
        src(DPSL_IF_PARALLEL, 0, 0, 0, 12'h140, 12'h0C7, 12'h00A, 1, 12'h140, 12'h0C7);
        src(DPSL_IF_PARALLEL, 0, 0, 0, 12'h140, 12'h0C8, 12'h009, 1, 12'h140, 12'h0C8);
        src(DPSL_IF_PARALLEL, 0, 0, 0, 12'h280, 12'h1E0, 12'h0F3, 1, 12'h280, 12'h1E0);
        src(DPSL_IF_PARALLEL, 1, 0, 0, 12'h500, 12'h2D0, 12'h066, 0, 12'h356, 12'h1E0);
        src(DPSL_IF_PARALLEL, 1, 0, 0, 12'h500, 12'h2D0, 12'h067, 1, 12'h356, 12'h1E0);
        src(DPSL_IF_PARALLEL, 1, 0, 0, 12'h500, 12'h2D0, 12'h076, 0, 12'h356, 12'h1E0);
        src(DPSL_IF_PARALLEL, 1, 0, 0, 12'h500, 12'h2D0, 12'h061, 1, 12'h356, 12'h1E0);
        src(DPSL_IF_PARALLEL, 1, 0, 0, 12'h500, 12'h2D1, 12'h078, 1, 12'h356, 12'h1E0);
        src(DPSL_IF_PARALLEL, 1, 0, 0, 12'h280, 12'h1E0, 12'h050, 1, 12'h280, 12'h1E0);
        src(DPSL_IF_PARALLEL, 1, 1, 0, 12'h2D0, 12'h500, 12'h078, 0, 12'h2D0, 12'h1E0);
        src(DPSL_IF_PARALLEL, 1, 1, 0, 12'h2D1, 12'h500, 12'h078, 1, 12'h2D1, 12'h1E0);
        src(DPSL_IF_DSI, 0, 0, 0, 12'h500, 12'h320, 12'h07A, 0, 12'h356, 12'h1E0);
        src(DPSL_IF_DSI, 0, 0, 0, 12'h500, 12'h320, 12'h07B, 1, 12'h356, 12'h1E0);
        // The source sends 16-bit pixels at this corner; the block sees only size and rate.
        src(DPSL_IF_DSI, 0, 0, 0, 12'h500, 12'h2D0, 12'h078, 0, 12'h356, 12'h1E0);
        src(DPSL_IF_BT_NTSC, 0, 0, 0, 12'h2D0, 12'h0F0, 12'h03C, 0, 12'h2D0, 12'h0F0);
        src(DPSL_IF_BT_NTSC, 0, 0, 0, 12'h2D0, 12'h0F0, 12'h03F, 1, 12'h2D0, 12'h0F0);
        src(DPSL_IF_BT_NTSC, 0, 1, 0, 12'h2D0, 12'h0F0, 12'h03C, 1, 12'h2D0, 12'h0F0);
        src(DPSL_IF_BT_PAL, 0, 0, 0, 12'h2D0, 12'h120, 12'h032, 0, 12'h2D0, 12'h120);
    endtask : sc_envelope
    task automatic sc_rotate();
        src(DPSL_IF_PARALLEL, 0, 1, 1, 12'h0C8, 12'h140, 12'h03C, 0, 12'h140, 12'h0C8);
        src(DPSL_IF_PARALLEL, 0, 1, 0, 12'h0C8, 12'h140, 12'h03C, 0, 12'h0C8, 12'h140);
        src(DPSL_IF_PARALLEL, 0, 1, 1, 12'h320, 12'h500, 12'h03C, 0, 12'h356, 12'h1E0);
        src(DPSL_IF_PARALLEL, 0, 1, 1, 12'h1E0, 12'h356, 12'h03C, 0, 12'h356, 12'h1E0);
    endtask : sc_rotate
    initial begin
        sys_rst = 1'b1;
        put_src(DPSL_IF_PARALLEL, 1'b0, 1'b0, 1'b0, 12'h000, 12'h000, 12'h000);
        repeat (10) @(negedge core_clk);
        chk1(src_fault, 1'b0);
        chk1(mirror_parked, 1'b0);
        sys_rst = 1'b0;
        sc_envelope();
        sc_rotate();
        sc_normal_park();
        sc_fast_park();
        sc_fast_cut();
        sc_mid_reset();
        conclude();
    end
endmodule : tb_top
